// >>> tb/rfr_exec_bench.sv
/*
  rfr_exec_bench: self-checking bench for rfr_exec with a register
  file model. Assumes the default micro-counter address 5'h01 and
  the class encoding order of rfr_pkg.
*/
`timescale 1ns/100ps
module rfr_exec_bench;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [15:0] pc_i = 16'h0000;
  logic [15:0] rf_rdata_i;
  logic instr_ready_o, done_o, branch_o, ms_start_o;
  rfr_pkg::rfr_class_type class_o;
  logic [15:0] feed_a_o, feed_b_o, sum_o;
  logic forced_carry_reg_o, sum_valid_o, link_o, ovf_o;
  int errors = 0;
  int comparisons = 0;
  logic [15:0] ea = 16'h0000;
  logic [15:0] eb = 16'h0000;
  logic ec = 1'b0;
  // class per group, group 0 in the low nibble
  localparam logic [63:0] CLS_MAP = 64'h4408765400312119;
  localparam logic [15:0] LOAD_OPS [8] = '{16'hD003, 16'hD404,
    16'h6005, 16'h6406, 16'hD807, 16'hDC08, 16'h7C09, 16'h7C0A};

  always #50 clk_i = ~clk_i;

  rfr_rf_model rfr_rf_model_i (.instr_i(instr_i),
    .rf_rdata_o(rf_rdata_i));
  rfr_exec rfr_exec_i (.clk_i(clk_i), .srst_i(srst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i),
    .instr_ready_o(instr_ready_o), .done_o(done_o),
    .class_o(class_o), .branch_o(branch_o), .ms_start_o(ms_start_o),
    .rf_rdata_i(rf_rdata_i), .feed_a_o(feed_a_o),
    .feed_b_o(feed_b_o), .forced_carry_reg_o(forced_carry_reg_o),
    .sum_o(sum_o), .sum_valid_o(sum_valid_o), .link_o(link_o),
    .ovf_o(ovf_o));

  task print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp,
    input string m);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [15:0] rf_exp(input logic [4:0] x);
    return (x == 5'h1F) ? 16'h8001 : {x, 3'h0, x, 3'h5};
  endfunction

  // expected feeder and carry effect of one word
  function automatic void model_exec(input logic [15:0] w);
    logic [15:0] v;
    v = rf_exp(w[4:0]);
    case (w[15:10])
      6'h34: ea = v;
      6'h35: begin ea = ~v; ec = 1'b1; end
      6'h18: begin eb = v; ec = 1'b0; end
      6'h19: begin eb = ~v; ec = 1'b1; end
      6'h36: begin ea = v; eb = v; ec = 1'b0; end
      6'h37: begin ea = 16'h0000; eb = v; ec = 1'b1; end
      6'h1F: begin eb = v; ec = pc_i[14]; end
      default: ;
    endcase
  endfunction

  // called on a falling edge; returns one falling edge after taking
  task send(input logic [15:0] w);
    int n;
    n = 0;
    model_exec(w);
    instr_i = w;
    instr_valid_i = 1'b1;
    while (instr_ready_o !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 8) begin
      errors++;
      print_verdict();
    end
    @(negedge clk_i);
  endtask

  task check_feed;
    check(feed_a_o, ea, "feeder a");
    check(feed_b_o, eb, "feeder b");
    check({15'h0, forced_carry_reg_o}, {15'h0, ec},
      "forced carry");
    check({15'h0, ms_start_o}, 16'h0000, "storage start");
  endtask

  task t_reset;
    check({15'h0, instr_ready_o}, 16'h0000, "ready in reset");
    check(16'(class_o), 16'h0009, "class in reset");
    check_feed();
    srst_i = 1'b0;
    @(negedge clk_i);
    check({15'h0, instr_ready_o}, 16'h0001, "ready after reset");
    $display("t_reset done");
  endtask

  task t_loads;
    for (int i = 0; i < 8; i++) begin
      pc_i = (i == 7) ? 16'h4000 : 16'hBFFF;
      send(LOAD_OPS[i]);
      check_feed();
      check({15'h0, done_o}, 16'h0001, "load done");
      check(16'(class_o), 16'h0000, "load class");
    end
    instr_valid_i = 1'b0;
    @(negedge clk_i);
    check({15'h0, done_o}, 16'h0000, "done pulse");
    $display("t_loads done");
  endtask

  task t_sum;
    send(16'hD81F);
    send(16'h2003);
    instr_valid_i = 1'b0;
    check({14'h0, instr_ready_o, done_o}, 16'h0000, "sum hold");
    @(negedge clk_i);
    check({14'h0, sum_valid_o, done_o}, 16'h0003, "held sum");
    check(sum_o, ea + eb + {15'h0, ec}, "sum value");
    check({14'h0, link_o, ovf_o}, 16'h0003, "link and overflow");
    send(16'h1003);
    send(16'h2404);
    instr_valid_i = 1'b0;
    check({14'h0, sum_valid_o, done_o}, 16'h0003, "fast sum");
    check(sum_o, ea + eb + {15'h0, ec}, "fast sum value");
    // a compare right behind a load is held too, yet yields no sum
    send(16'hD81F);
    send(16'h2803);
    instr_valid_i = 1'b0;
    check({13'h0, instr_ready_o, done_o, sum_valid_o}, 16'h0000,
      "compare hold");
    @(negedge clk_i);
    check({14'h0, sum_valid_o, done_o}, 16'h0001,
      "held compare");
    $display("t_sum done");
  endtask

  task t_branch;
    for (int v = 0; v < 4; v++) begin
      send({4'h1, 2'(v), 10'h001});
      check({15'h0, branch_o}, 16'h0001, "branch on counter");
      check(16'(class_o), 16'h0001, "write class");
      send({4'h1, 2'(v), 10'h002});
      check({15'h0, branch_o}, 16'h0000, "no branch");
    end
    instr_valid_i = 1'b0;
    @(negedge clk_i);
    $display("t_branch done");
  endtask

  task t_classes;
    for (int g = 0; g < 16; g++) begin
      send({4'(g), 12'h002});
      check(16'(class_o), {12'h0, CLS_MAP[g*4 +: 4]}, "class");
      check_feed();
    end
    instr_valid_i = 1'b0;
    @(negedge clk_i);
    $display("t_classes done");
  endtask

  initial begin
    repeat (16) @(negedge clk_i);
    t_reset();
    t_loads();
    t_sum();
    t_branch();
    t_classes();
    print_verdict();
  end
endmodule // rfr_exec_bench

// >>> tb/rfr_rf_model.sv
/*
  rfr_rf_model: register file read port seen by the executor.
  Assumes the word is addressed by the X-field of instr_i and is
  returned in the same cycle, as the executor samples it at the
  taking edge.
*/
`timescale 1ns/100ps
module rfr_rf_model (
  // sequencer side
  input wire logic [15:0] instr_i,
  // read port
  output logic [15:0] rf_rdata_o
);
  wire logic [4:0] addr;
  assign addr = instr_i[4:0];
  // a fixed negative word 16'h8001 at 5'h1F so sums can carry and overflow
  assign rf_rdata_o = (addr == 5'h1F) ? 16'h8001 :
    {addr, 3'h0, addr, 3'h5};
endmodule // rfr_rf_model

// >>> verilog/rfr_exec.sv
/*
  rfr_exec: decodes each micro-instruction into its class, executes
  the register-file-read class (feeder loads, forced carry), the sum
  that consumes the feeders, and flags branches caused by writes to
  the micro-program counter by GRP_RFW (group 1) words only.
  Assumes the register file decodes the X-field straight from
  instr_i and returns rf_rdata_i in the same cycle; pc_i is the
  micro-program counter from the sequencer on the same clock.
*/
`timescale 1ns/100ps
module rfr_exec #(
  parameter logic [rfr_pkg::XF_W-1:0] PMU_ADDR = 5'h01
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // sequencer
  input wire logic instr_valid_i,
  input wire logic [rfr_pkg::WORD_W-1:0] instr_i,
  input wire logic [rfr_pkg::WORD_W-1:0] pc_i,
  output logic instr_ready_o,
  output logic done_o,
  output rfr_pkg::rfr_class_type class_o,
  output logic branch_o,
  output logic ms_start_o,
  // register file
  input wire logic [rfr_pkg::WORD_W-1:0] rf_rdata_i,
  // feeders and alu
  output logic [rfr_pkg::WORD_W-1:0] feed_a_o,
  output logic [rfr_pkg::WORD_W-1:0] feed_b_o,
  output logic forced_carry_reg_o,
  output logic [rfr_pkg::WORD_W-1:0] sum_o,
  output logic sum_valid_o,
  output logic link_o,
  output logic ovf_o
);

  // refused at elaboration: the hold logic covers exactly one cycle
  if (rfr_pkg::EXEC_CYC != 1 || rfr_pkg::SETTLE_CYC != 1) begin : g_timing
    $error("rfr_exec serves only one-cycle execute and settle");
  end

  typedef enum logic {ST_RUN, ST_HOLD} rfr_state_type;

  function automatic rfr_pkg::rfr_class_type classify(
    input logic [3:0] grp
  );
    rfr_pkg::rfr_class_type c;
    c = rfr_pkg::CLS_CONTROL;
    case (grp)
      4'h1, 4'h2, 4'h4: c = rfr_pkg::CLS_RF_WRITE;
      4'h3: c = rfr_pkg::CLS_RF_READ_MS;
      4'h5: c = rfr_pkg::CLS_RF_WRITE_MS;
      4'h6, 4'h7, 4'hD: c = rfr_pkg::CLS_RF_READ;
      4'h8, 4'hE, 4'hF: c = rfr_pkg::CLS_IMMEDIATE;
      4'h9: c = rfr_pkg::CLS_SHIFT;
      4'hA: c = rfr_pkg::CLS_BIT_SENSE;
      4'hB: c = rfr_pkg::CLS_SKIP;
      4'hC: c = rfr_pkg::CLS_BRANCH;
      default: c = rfr_pkg::CLS_CONTROL;
    endcase
    return c;
  endfunction

  rfr_state_type state_r, state_nxt;
  logic ready_r, done_r, branch_r, ms_start_r, settle_r;
  logic fcr_r, sum_valid_r, link_r, ovf_r;
  // held compare must not produce a sum, so remember the held variant
  logic hold_sum_op_r;
  logic [rfr_pkg::WORD_W-1:0] feed_a_r, feed_b_r, sum_r;
  logic [rfr_pkg::WORD_W-1:0] feed_a_nxt, feed_b_nxt;
  logic fcr_nxt;
  rfr_pkg::rfr_class_type class_r;

  // decode
  wire logic accept = instr_valid_i & ready_r;
  wire logic [3:0] grp = instr_i[rfr_pkg::GRP_HI:rfr_pkg::GRP_LO];
  wire logic [1:0] vari = instr_i[rfr_pkg::VAR_HI:rfr_pkg::VAR_LO];
  wire logic [rfr_pkg::XF_W-1:0] xfield =
    instr_i[rfr_pkg::XF_LO +: rfr_pkg::XF_W];
  wire rfr_pkg::rfr_class_type cls = classify(grp);
  wire logic op_la = grp == rfr_pkg::GRP_LDA && vari == rfr_pkg::VAR_0;
  wire logic op_lac = grp == rfr_pkg::GRP_LDA && vari == rfr_pkg::VAR_1;
  wire logic op_lab = grp == rfr_pkg::GRP_LDA && vari == rfr_pkg::VAR_2;
  wire logic op_cla = grp == rfr_pkg::GRP_LDA && vari == rfr_pkg::VAR_3;
  wire logic op_lb = grp == rfr_pkg::GRP_LDB && vari == rfr_pkg::VAR_0;
  wire logic op_lbc = grp == rfr_pkg::GRP_LDB && vari == rfr_pkg::VAR_1;
  wire logic op_lbl = grp == rfr_pkg::GRP_LBL && vari == rfr_pkg::VAR_3;
  wire logic feed_load = op_la | op_lac | op_lab | op_cla | op_lb |
    op_lbc | op_lbl;
  wire logic sum_cls = grp == rfr_pkg::GRP_SUM;
  wire logic sum_op = sum_cls &&
    (vari == rfr_pkg::VAR_0 || vari == rfr_pkg::VAR_1);
  // clear, store-A, store-B and logical product: 1,0..1,3
  wire logic pmu_write = grp == rfr_pkg::GRP_RFW && xfield == PMU_ADDR;
  // a sum right behind a feeder load must wait for the alu
  wire logic must_hold = accept & sum_cls & settle_r;
  wire logic hold_sum = state_r == ST_HOLD;
  wire logic do_sum = (accept & sum_op & ~settle_r) |
    (hold_sum & hold_sum_op_r);

  // alu: both feeders plus forced carry
  wire logic [rfr_pkg::WORD_W:0] sum_ext =
    {1'b0, feed_a_r} + {1'b0, feed_b_r} +
    {{rfr_pkg::WORD_W{1'b0}}, fcr_r};
  wire logic sum_ovf =
    (feed_a_r[rfr_pkg::WORD_W-1] == feed_b_r[rfr_pkg::WORD_W-1]) &&
    (sum_ext[rfr_pkg::WORD_W-1] != feed_a_r[rfr_pkg::WORD_W-1]);

  // feeder next values; unlisted opcodes leave feeders alone
  always_comb begin
    feed_a_nxt = feed_a_r;
    feed_b_nxt = feed_b_r;
    fcr_nxt = fcr_r;
    if (accept) begin
      if (op_la) begin
        feed_a_nxt = rf_rdata_i;
      end else if (op_lac) begin
        feed_a_nxt = ~rf_rdata_i;
        fcr_nxt = 1'b1;
      end else if (op_lb) begin
        feed_b_nxt = rf_rdata_i;
        fcr_nxt = 1'b0;
      end else if (op_lbc) begin
        feed_b_nxt = ~rf_rdata_i;
        fcr_nxt = 1'b1;
      end else if (op_lab) begin
        feed_a_nxt = rf_rdata_i;
        feed_b_nxt = rf_rdata_i;
        fcr_nxt = 1'b0;
      end else if (op_cla) begin
        feed_a_nxt = rfr_pkg::ZERO_W;
        feed_b_nxt = rf_rdata_i;
        fcr_nxt = 1'b1;
      end else if (op_lbl) begin
        feed_b_nxt = rf_rdata_i;
        fcr_nxt = pc_i[rfr_pkg::LINK_BIT];
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: if (must_hold) state_nxt = ST_HOLD;
      ST_HOLD: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= ST_RUN;
      feed_a_r <= rfr_pkg::ZERO_W;
      feed_b_r <= rfr_pkg::ZERO_W;
      fcr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      feed_a_r <= feed_a_nxt;
      feed_b_r <= feed_b_nxt;
      fcr_r <= fcr_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ready_r <= 1'b0;
      done_r <= 1'b0;
      settle_r <= 1'b0;
      class_r <= rfr_pkg::CLS_CONTROL;
      branch_r <= 1'b0;
      ms_start_r <= 1'b0;
    end else begin
      // ready drops only for the settle cycle of a held GRP_SUM word (sum or compare)
      ready_r <= ~must_hold;
      done_r <= (accept & ~must_hold) | hold_sum;
      settle_r <= accept & feed_load;
      if (accept) class_r <= cls;
      branch_r <= accept & pmu_write;
      // no class handled here starts a storage cycle
      ms_start_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sum_r <= rfr_pkg::ZERO_W;
      sum_valid_r <= 1'b0;
      link_r <= 1'b0;
      ovf_r <= 1'b0;
      hold_sum_op_r <= 1'b0;
    end else begin
      sum_valid_r <= do_sum;
      if (must_hold) hold_sum_op_r <= sum_op;
      if (do_sum) begin
        sum_r <= sum_ext[rfr_pkg::WORD_W-1:0];
        link_r <= sum_ext[rfr_pkg::WORD_W];
        ovf_r <= sum_ovf;
      end
    end
  end

  assign instr_ready_o = ready_r;
  assign done_o = done_r;
  assign class_o = class_r;
  assign branch_o = branch_r;
  assign ms_start_o = ms_start_r;
  assign feed_a_o = feed_a_r;
  assign feed_b_o = feed_b_r;
  assign forced_carry_reg_o = fcr_r;
  assign sum_o = sum_r;
  assign sum_valid_o = sum_valid_r;
  assign link_o = link_r;
  assign ovf_o = ovf_r;

  // checks
  property p_law;
    @(posedge clk_i) disable iff (srst_i)
    accept && op_la |=> feed_a_o == $past(rf_rdata_i) && done_o;
  endproperty
  a_law: assert property (p_law) else $error("load A wrong");

  property p_lac;
    @(posedge clk_i) disable iff (srst_i)
    accept && op_lac |=> feed_a_o == ~$past(rf_rdata_i) &&
      forced_carry_reg_o;
  endproperty
  a_lac: assert property (p_lac) else $error("load A compl wrong");

  property p_lb;
    @(posedge clk_i) disable iff (srst_i)
    accept && op_lb |=> feed_b_o == $past(rf_rdata_i) &&
      !forced_carry_reg_o && $stable(feed_a_o);
  endproperty
  a_lb: assert property (p_lb) else $error("load B wrong");

  property p_lbc;
    @(posedge clk_i) disable iff (srst_i)
    accept && op_lbc |=> feed_b_o == ~$past(rf_rdata_i) &&
      forced_carry_reg_o;
  endproperty
  a_lbc: assert property (p_lbc) else $error("load B compl wrong");

  property p_lab;
    @(posedge clk_i) disable iff (srst_i)
    accept && op_lab |=> feed_a_o == feed_b_o &&
      feed_a_o == $past(rf_rdata_i) && !forced_carry_reg_o;
  endproperty
  a_lab: assert property (p_lab) else $error("load A and B wrong");

  property p_cla;
    @(posedge clk_i) disable iff (srst_i)
    accept && op_cla |=> feed_a_o == rfr_pkg::ZERO_W &&
      feed_b_o == $past(rf_rdata_i) && forced_carry_reg_o;
  endproperty
  a_cla: assert property (p_cla) else $error("clear A wrong");

  property p_lbl;
    @(posedge clk_i) disable iff (srst_i)
    accept && op_lbl |=>
      forced_carry_reg_o == $past(pc_i[rfr_pkg::LINK_BIT]) &&
      feed_b_o == $past(rf_rdata_i);
  endproperty
  a_lbl: assert property (p_lbl) else $error("link carry wrong");

  property p_branch;
    @(posedge clk_i) disable iff (srst_i)
    accept && grp == rfr_pkg::GRP_RFW |=> branch_o == $past(pmu_write);
  endproperty
  a_branch: assert property (p_branch) else $error("branch wrong");

  property p_hold;
    @(posedge clk_i) disable iff (srst_i)
    accept && feed_load ##1 accept && sum_op |=>
      !instr_ready_o && !sum_valid_o ##1 sum_valid_o && done_o;
  endproperty
  a_hold: assert property (p_hold) else $error("sum not held");

  property p_sum;
    @(posedge clk_i) disable iff (srst_i)
    do_sum |=> sum_o == $past(feed_a_o) + $past(feed_b_o) +
      {{(rfr_pkg::WORD_W-1){1'b0}}, $past(forced_carry_reg_o)};
  endproperty
  a_sum: assert property (p_sum) else $error("sum wrong");

  property p_noms;
    @(posedge clk_i) disable iff (srst_i)
    accept && cls == rfr_pkg::CLS_RF_READ |=> !ms_start_o;
  endproperty
  a_noms: assert property (p_noms) else $error("storage started");

  c_hold: cover property (@(posedge clk_i) disable iff (srst_i)
    accept && feed_load ##1 must_hold);
  c_fast: cover property (@(posedge clk_i) disable iff (srst_i)
    accept && sum_op && !settle_r);
  c_branch: cover property (@(posedge clk_i) disable iff (srst_i)
    branch_o);
  c_lbl: cover property (@(posedge clk_i) disable iff (srst_i)
    accept && op_lbl && pc_i[rfr_pkg::LINK_BIT]);

endmodule // rfr_exec

// >>> verilog/rfr_pkg.sv
/*
  rfr_pkg: constants for the register-file-read micro-instruction
  executor: opcode groups and variants, field positions, timing.
  Assumes a 16-bit micro-instruction with bit 15 the first
  (most significant) bit of the printed format.
*/
package rfr_pkg;
  localparam int WORD_W = 16;
  localparam int XF_W = 5;
  // opcode: class group in the top nibble, variant in next two bits
  localparam int GRP_HI = 15;
  localparam int GRP_LO = 12;
  localparam int VAR_HI = 11;
  localparam int VAR_LO = 10;
  localparam int XF_LO = 0;
  // link status sits in printed bit 1 of the micro-program counter
  localparam int LINK_BIT = 14;
  localparam logic [3:0] GRP_RFW = 4'h1;
  localparam logic [3:0] GRP_SUM = 4'h2;
  localparam logic [3:0] GRP_LOGIC = 4'h4;
  localparam logic [3:0] GRP_LDB = 4'h6;
  localparam logic [3:0] GRP_LBL = 4'h7;
  localparam logic [3:0] GRP_LDA = 4'hD;
  localparam logic [1:0] VAR_0 = 2'h0;
  localparam logic [1:0] VAR_1 = 2'h1;
  localparam logic [1:0] VAR_2 = 2'h2;
  localparam logic [1:0] VAR_3 = 2'h3;
  localparam logic [WORD_W-1:0] ZERO_W = 16'h0000;
  // timing in ns at the 100 ns minor cycle
  localparam int CLK_NS = 100;
  localparam int EXEC_NS = 100;
  localparam int SETTLE_NS = 100;
  localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [3:0] {
    CLS_RF_READ,
    CLS_RF_WRITE,
    CLS_RF_READ_MS,
    CLS_RF_WRITE_MS,
    CLS_IMMEDIATE,
    CLS_SHIFT,
    CLS_BIT_SENSE,
    CLS_SKIP,
    CLS_BRANCH,
    CLS_CONTROL
  } rfr_class_type;
endpackage
